// ### src/adc_seq_pkg.sv
// Shared constants, types and register map of the converter sequencer.
package adc_seq_pkg;

  localparam int NSEQ  = 4;
  localparam int NSTEP = 8;
  localparam int NCMP  = 8;
  localparam int DW    = 12;

  localparam logic [4:0] CH_TEMP     = 5'h18;
  localparam logic [2:0] OS_MAX      = 3'h6;
  localparam logic [3:0] TRIG_PROC   = 4'h0;
  localparam logic [3:0] TRIG_EXT_LO = 4'h1;
  localparam logic [3:0] TRIG_EXT_HI = 4'h4;
  localparam logic [3:0] TRIG_ALWAYS = 4'hF;
  localparam logic [1:0] BAND_LOW    = 2'h0;
  localparam logic [1:0] BAND_MID    = 2'h1;
  localparam logic [1:0] BAND_HIGH   = 2'h2;
  localparam logic [1:0] BAND_NONE   = 2'h3;

  localparam logic [11:0] OFS_ENABLE = 12'h000;
  localparam logic [11:0] OFS_PTRIG  = 12'h004;
  localparam logic [11:0] OFS_OVSMP  = 12'h008;
  localparam logic [11:0] OFS_RIS    = 12'h00C;
  localparam logic [11:0] OFS_IMASK  = 12'h010;
  localparam logic [11:0] OFS_MIS    = 12'h014;
  localparam logic [11:0] OFS_ICLR   = 12'h018;
  localparam logic [11:0] OFS_OVF    = 12'h01C;
  localparam logic [11:0] OFS_UNF    = 12'h020;
  localparam logic [11:0] OFS_TSEL   = 12'h024;
  localparam logic [11:0] OFS_PRIO   = 12'h028;
  localparam logic [11:0] OFS_STEP   = 12'h02C;
  localparam logic [11:0] OFS_FIFO0  = 12'h030;
  localparam logic [11:0] OFS_FIFO3  = 12'h03C;
  localparam logic [11:0] OFS_FCNT   = 12'h040;
  localparam logic [11:0] OFS_CRIS   = 12'h044;
  localparam logic [11:0] OFS_CRST   = 12'h048;
  localparam logic [11:0] OFS_CMP    = 12'h080;
  localparam logic [11:0] OFS_CMPEND = 12'h0C0;

  localparam int STEP_IDX_LSB = 16;
  localparam int STEP_SEQ_LSB = 20;
  localparam int CRST_IRQ_LSB = 8;
  localparam int REF_HI_LSB   = 16;

  typedef enum logic [3:0] {
    fault_trig_off,
    fault_trig_lowband_each,
    fault_trig_lowband_entry,
    fault_trig_lowband_hyst_each,
    fault_trig_lowband_hyst_entry,
    fault_trig_midband_each,
    fault_trig_midband_entry,
    fault_trig_highband_each,
    fault_trig_highband_entry,
    fault_trig_highband_hyst_each,
    fault_trig_highband_hyst_entry
  } cmp_mode_t;

  localparam logic [3:0] cmp_irq_lowband_hyst_each   = 4'h3;
  localparam logic [3:0] cmp_irq_lowband_hyst_entry  = 4'h4;
  localparam logic [3:0] cmp_irq_highband_hyst_each  = 4'h9;
  localparam logic [3:0] cmp_irq_highband_hyst_entry = 4'hA;

  typedef enum logic [1:0] {RS_IDLE, RS_ISSUE, RS_WAIT} run_state_t;

  typedef struct packed {
    logic [2:0] cmpSel;
    logic       cmpEn;
    logic       last;
    logic [4:0] ch;
  } step_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic       start;
    logic [4:0] ch;
  } conv_req_t;

  typedef struct packed {
    logic          done;
    logic [DW-1:0] data;
  } conv_rsp_t;

  function automatic logic [3:0] seqDepth(input logic [1:0] s);
    case (s)
      2'h0:    seqDepth = 4'h8;
      2'h1:    seqDepth = 4'h4;
      2'h2:    seqDepth = 4'h4;
      default: seqDepth = 4'h1;
    endcase
  endfunction : seqDepth

endpackage : adc_seq_pkg

// ### src/adc_cmp_unit.sv
// One digital comparator with separate fault-trigger and interrupt history.
`timescale 1ns/1ps
module adc_cmp_unit (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   resValid,
  input  wire logic [adc_seq_pkg::DW-1:0] resData,
  input  wire logic [adc_seq_pkg::DW-1:0] lowRef,
  input  wire logic [adc_seq_pkg::DW-1:0] highRef,
  input  wire logic [3:0]             trigMode,
  input  wire logic [3:0]             irqMode,
  input  wire logic                   rstTrig,
  input  wire logic                   rstIrq,
  output logic                        trigPulse,
  output logic                        irqPulse
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic [1:0] prevT;
    logic [1:0] prevI;
    logic       armT;
    logic       armI;
    logic       outT;
    logic       outI;
  } cmp_state_t;

  cmp_state_t s_reg, s_next;
  logic [1:0] band;
  logic [1:0] evT, evI;

  // Returns {fire, armed-next} for one output channel
  function automatic logic [1:0] evalMode(input logic [3:0] m,
      input logic [1:0] b, input logic [1:0] p, input logic a);
    logic [1:0] tgt;
    logic [1:0] opp;
    logic       ent, hys, on, f;
    tgt = BAND_LOW; opp = BAND_HIGH; ent = 1'b0; hys = 1'b0; on = 1'b1;
    case (m)
      fault_trig_lowband_each:        ;
      fault_trig_lowband_entry:       ent = 1'b1;
      fault_trig_lowband_hyst_each:   hys = 1'b1;
      fault_trig_lowband_hyst_entry:  begin ent = 1'b1; hys = 1'b1; end
      fault_trig_midband_each:        tgt = BAND_MID;
      fault_trig_midband_entry:       begin tgt = BAND_MID; ent = 1'b1; end
      fault_trig_highband_each:       tgt = BAND_HIGH;
      fault_trig_highband_entry:      begin tgt = BAND_HIGH; ent = 1'b1; end
      fault_trig_highband_hyst_each:  begin tgt = BAND_HIGH; opp = BAND_LOW;
        hys = 1'b1; end
      fault_trig_highband_hyst_entry: begin tgt = BAND_HIGH; opp = BAND_LOW;
        hys = 1'b1; ent = 1'b1; end
      default:                        on = 1'b0;
    endcase
    f = on && (b == tgt) && (!ent || p != tgt) && (!hys || a);
    evalMode = {f, hys && !f && (a || b == opp)};
  endfunction : evalMode

  assign band = (resData <= lowRef) ? BAND_LOW :
                (resData <= highRef) ? BAND_MID : BAND_HIGH;
  assign evT = evalMode(trigMode, band, s_reg.prevT, s_reg.armT);
  assign evI = evalMode(irqMode, band, s_reg.prevI, s_reg.armI);

  always_comb
  begin
    s_next = s_reg;
    s_next.outT = 1'b0;
    s_next.outI = 1'b0;
    if (resValid)
    begin
      s_next.prevT = band;
      s_next.prevI = band;
      s_next.armT  = evT[0];
      s_next.armI  = evI[0];
      s_next.outT  = evT[1];
      s_next.outI  = evI[1];
    end
    if (rstTrig)
    begin
      s_next.prevT = BAND_NONE;
      s_next.armT  = 1'b0;
    end
    if (rstIrq)
    begin
      s_next.prevI = BAND_NONE;
      s_next.armI  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '{prevT: BAND_NONE, prevI: BAND_NONE, default: '0};
    else
      s_reg <= s_next;
  end

  assign trigPulse = s_reg.outT;
  assign irqPulse  = s_reg.outI;

endmodule : adc_cmp_unit

// ### src/adc_sequencer.sv
// Sample sequencers, averaging, result FIFOs and comparator routing.
// Notes on behaviour
// - Four sequencers of depth eight, four, four, one
// - Steps pick any of 24 channels or temp
// - Each sequencer has own trigger source, steps
// - Highest priority pending sequencer is sampled first
// - Hardware averaging of 2x up to 64x
// - One averaging factor shared by all sequencers
// - Per-FIFO overflow and underflow flags, clearable
// - Disabled sequencer ignores its triggers
// - Software processor trigger starts chosen sequencers
// - Per-sequencer interrupt with mask, status, clear
// - Comparator config holds trigger and interrupt modes
// - Disabled trigger mode never asserts fault output
// - Always trigger mode fires on every band hit
// - Once mode fires only on band entry
// - Low hysteresis needs high band since last fire
// - High hysteresis needs low band since last
// - Disabled interrupt mode never raises interrupt
// - Always interrupt mode fires on every band hit
// - Once interrupt mode fires on band entry
// - Bands split at or below low, high reference
// - Software resets comparator history, trigger or interrupt
// - Each FIFO entry is a fully averaged result
// - Interrupt status readable raw and masked
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module adc_sequencer (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire adc_seq_pkg::apb_req_t    apbReq,
  output adc_seq_pkg::apb_rsp_t         apbRsp,
  input  wire logic [3:0]               trigIn,
  output adc_seq_pkg::conv_req_t        convReq,
  input  wire adc_seq_pkg::conv_rsp_t   convRsp,
  output logic [adc_seq_pkg::NCMP-1:0]  faultTrig
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic [3:0]              seqEn;
    logic [3:0]              pend;
    logic [2:0]              osFactor;
    logic [3:0]              ris;
    logic [3:0]              imask;
    logic [3:0]              ovf;
    logic [3:0]              unf;
    logic [15:0]             trigSel;
    logic [7:0]              prio;
    logic [NCMP-1:0]         cmpRis;
    logic [31:0][9:0]        steps;
    logic [31:0][DW-1:0]     fifo;
    logic [3:0][2:0]         wp;
    logic [3:0][2:0]         rp;
    logic [3:0][3:0]         cnt;
    run_state_t              st;
    logic [1:0]              cur;
    logic [2:0]              step;
    logic [5:0]              osCnt;
    logic [17:0]             acc;
    logic                    convStart;
    logic [4:0]              convCh;
    logic [NCMP-1:0][7:0]    cmpMode;
    logic [NCMP-1:0][31:0]   cmpRef;
    logic [3:0]              trigD;
    logic [DW-1:0]           resData;
    logic [NCMP-1:0]         resValid;
    logic [NCMP-1:0]         rstT;
    logic [NCMP-1:0]         rstI;
    logic [31:0]             prdata;
    logic                    pslverr;
  } seq_state_t;

  seq_state_t s_reg, s_next;

  logic            wrAcc, rdAcc, setup;
  logic [11:0]     addr;
  logic [31:0]     wd;
  logic [3:0]      hit, procHit, rise;
  logic [2:0]      pick;
  logic [17:0]     accSum;
  logic [5:0]      osLast;
  step_cfg_t       curStep;
  logic [NCMP-1:0] trigP, irqP;

  // Lowest priority value wins, lower index breaks ties
  function automatic logic [2:0] pickSeq(input logic [3:0] p,
      input logic [7:0] pr);
    logic [2:0] r;
    logic [1:0] best;
    r = 3'h0;
    best = 2'h3;
    for (int i = NSEQ - 1; i >= 0; i--)
      if (p[i] && (pr[2*i+:2] <= best || !r[2]))
      begin
        if (!r[2] || pr[2*i+:2] <= best)
        begin
          r = {1'b1, 2'(i)};
          best = pr[2*i+:2];
        end
      end
    pickSeq = r;
  endfunction : pickSeq

  function automatic logic [2:0] wrapInc(input logic [2:0] p,
      input logic [1:0] q);
    wrapInc = ({1'b0, p} + 4'h1 == seqDepth(q)) ? 3'h0 : p + 3'h1;
  endfunction : wrapInc

  function automatic logic [31:0] readMux(input seq_state_t s,
      input logic [11:0] a);
    logic [31:0] r;
    logic [1:0]  q;
    logic [2:0]  c;
    r = 32'h0;
    q = a[3:2];
    c = a[5:3];
    case (a)
      OFS_ENABLE: r[3:0] = s.seqEn;
      OFS_OVSMP:  r[2:0] = s.osFactor;
      OFS_RIS:    r[3:0] = s.ris;
      OFS_IMASK:  r[3:0] = s.imask;
      OFS_MIS:    r[3:0] = s.ris & s.imask;
      OFS_OVF:    r[3:0] = s.ovf;
      OFS_UNF:    r[3:0] = s.unf;
      OFS_TSEL:   r[15:0] = s.trigSel;
      OFS_PRIO:   r[7:0] = s.prio;
      OFS_FCNT:   r[15:0] = s.cnt;
      OFS_CRIS:   r[NCMP-1:0] = s.cmpRis;
      default:
      begin
        if (a >= OFS_FIFO0 && a <= OFS_FIFO3 && s.cnt[q] != 4'h0)
          r[DW-1:0] = s.fifo[{q, s.rp[q]}];
        else if (a >= OFS_CMP && a < OFS_CMPEND)
          r = a[2] ? s.cmpRef[c] : {24'h0, s.cmpMode[c]};
      end
    endcase
    readMux = r;
  endfunction : readMux

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= OFS_CRST
      || (a >= OFS_CMP && a < OFS_CMPEND));
  endfunction : isMapped

  assign addr    = apbReq.paddr;
  assign wd      = apbReq.pwdata;
  assign setup   = apbReq.psel && !apbReq.penable;
  assign wrAcc   = apbReq.psel && apbReq.penable && apbReq.pwrite
                   && isMapped(addr);
  assign rdAcc   = apbReq.psel && apbReq.penable && !apbReq.pwrite
                   && isMapped(addr);
  assign procHit = (wrAcc && addr == OFS_PTRIG) ? wd[3:0] : 4'h0;
  assign rise    = trigIn & ~s_reg.trigD;
  assign pick    = pickSeq(s_reg.pend, s_reg.prio);
  assign curStep = s_reg.steps[{s_reg.cur, s_reg.step}];
  assign accSum  = s_reg.acc + {6'h0, convRsp.data};
  assign osLast  = (6'h1 << s_reg.osFactor) - 6'h1;

  always_comb
  begin
    for (int i = 0; i < NSEQ; i++)
    begin
      logic [3:0] src;
      src = s_reg.trigSel[4*i+:4];
      hit[i] = (src == TRIG_ALWAYS) || (src == TRIG_PROC && procHit[i])
        || (src >= TRIG_EXT_LO && src <= TRIG_EXT_HI
            && rise[2'(src - TRIG_EXT_LO)]);
    end
  end

  always_comb
  begin
    logic [1:0] q;
    logic [1:0] ws;
    logic [2:0] cx;
    q  = addr[3:2];
    ws = wd[STEP_SEQ_LSB+:2];
    cx = addr[5:3];
    s_next = s_reg;
    s_next.convStart = 1'b0;
    s_next.resValid  = '0;
    s_next.rstT      = '0;
    s_next.rstI      = '0;
    s_next.trigD     = trigIn;
    if (setup)
    begin
      s_next.prdata  = isMapped(addr) ? readMux(s_reg, addr) : 32'h0;
      s_next.pslverr = !isMapped(addr);
    end
    if (wrAcc)
    begin
      case (addr)
        OFS_ENABLE: s_next.seqEn = wd[3:0];
        OFS_OVSMP:  s_next.osFactor = (wd[2:0] > OS_MAX) ? OS_MAX
                                      : wd[2:0];
        OFS_IMASK:  s_next.imask = wd[3:0];
        OFS_ICLR:   s_next.ris = s_reg.ris & ~wd[3:0];
        OFS_OVF:    s_next.ovf = s_reg.ovf & ~wd[3:0];
        OFS_UNF:    s_next.unf = s_reg.unf & ~wd[3:0];
        OFS_TSEL:   s_next.trigSel = wd[15:0];
        OFS_PRIO:   s_next.prio = wd[7:0];
        OFS_STEP:
          if ({1'b0, wd[STEP_IDX_LSB+:3]} < seqDepth(ws))
            s_next.steps[{ws, wd[STEP_IDX_LSB+:3]}] = wd[9:0];
        OFS_CRIS:   s_next.cmpRis = s_reg.cmpRis & ~wd[NCMP-1:0];
        OFS_CRST:
        begin
          s_next.rstT = wd[NCMP-1:0];
          s_next.rstI = wd[CRST_IRQ_LSB+:NCMP];
        end
        default:
          if (addr >= OFS_CMP && addr < OFS_CMPEND)
          begin
            if (addr[2])
              s_next.cmpRef[cx] = wd & 32'h0FFF0FFF;
            else
              s_next.cmpMode[cx] = wd[7:0];
          end
      endcase
    end
    // Read pops the head; reading an empty FIFO flags underflow
    if (rdAcc && addr >= OFS_FIFO0 && addr <= OFS_FIFO3)
    begin
      if (s_reg.cnt[q] == 4'h0)
        s_next.unf[q] = 1'b1;
      else
      begin
        s_next.rp[q]  = wrapInc(s_reg.rp[q], q);
        s_next.cnt[q] = s_next.cnt[q] - 4'h1;
      end
    end
    case (s_reg.st)
      RS_IDLE:
        if (pick[2])
        begin
          s_next.cur = pick[1:0];
          s_next.step = 3'h0;
          s_next.osCnt = 6'h0;
          s_next.acc = 18'h0;
          s_next.pend[pick[1:0]] = 1'b0;
          s_next.st = RS_ISSUE;
        end
      RS_ISSUE:
      begin
        s_next.convStart = 1'b1;
        s_next.convCh = curStep.ch;
        s_next.st = RS_WAIT;
      end
      RS_WAIT:
        if (convRsp.done)
        begin
          s_next.st = RS_ISSUE;
          if (s_reg.osCnt != osLast)
          begin
            s_next.osCnt = s_reg.osCnt + 6'h1;
            s_next.acc = accSum;
          end
          else
          begin
            s_next.osCnt = 6'h0;
            s_next.acc = 18'h0;
            s_next.resData = 12'(accSum >> s_reg.osFactor);
            if (curStep.cmpEn)
              s_next.resValid[curStep.cmpSel] = 1'b1;
            if (s_next.cnt[s_reg.cur] == seqDepth(s_reg.cur))
              s_next.ovf[s_reg.cur] = 1'b1;
            else
            begin
              s_next.fifo[{s_reg.cur, s_reg.wp[s_reg.cur]}] =
                12'(accSum >> s_reg.osFactor);
              s_next.wp[s_reg.cur] = wrapInc(s_reg.wp[s_reg.cur],
                                             s_reg.cur);
              s_next.cnt[s_reg.cur] = s_next.cnt[s_reg.cur] + 4'h1;
            end
            if (curStep.last
                || {1'b0, s_reg.step} + 4'h1 == seqDepth(s_reg.cur))
            begin
              s_next.ris[s_reg.cur] = 1'b1;
              s_next.st = RS_IDLE;
            end
            else
              s_next.step = s_reg.step + 3'h1;
          end
        end
      default: s_next.st = RS_IDLE;
    endcase
    // Set wins over a clear in the same cycle
    s_next.cmpRis = s_next.cmpRis | irqP;
    s_next.pend = (s_next.pend | hit) & s_next.seqEn;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '{st: RS_IDLE, default: '0};
    else
      s_reg <= s_next;
  end

  // The comparator picked by cmpSel sees each averaged result of a cmpEn step once it is final
  for (genvar g = 0; g < NCMP; g++)
  begin : gCmp
    adc_cmp_unit uCmp (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .resValid  (s_reg.resValid[g]),
      .resData   (s_reg.resData),
      .lowRef    (s_reg.cmpRef[g][DW-1:0]),
      .highRef   (s_reg.cmpRef[g][REF_HI_LSB+:DW]),
      .trigMode  (s_reg.cmpMode[g][3:0]),
      .irqMode   (s_reg.cmpMode[g][7:4]),
      .rstTrig   (s_reg.rstT[g]),
      .rstIrq    (s_reg.rstI[g]),
      .trigPulse (trigP[g]),
      .irqPulse  (irqP[g])
    );
  end

  // Zero-wait slave: read data is captured in the setup cycle
  assign apbRsp.prdata  = s_reg.prdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = s_reg.pslverr && apbReq.penable;
  assign convReq.start  = s_reg.convStart;
  assign convReq.ch     = s_reg.convCh;
  assign faultTrig      = trigP;

endmodule : adc_sequencer

// ### testbench/adc_sequencer_properties.sv
// Port-level properties of the converter sequencer.
`timescale 1ns/1ps
module adc_sequencer_properties (
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  input  wire adc_seq_pkg::apb_req_t       apbReq,
  input  wire adc_seq_pkg::apb_rsp_t       apbRsp,
  input  wire logic [3:0]                  trigIn,
  input  wire adc_seq_pkg::conv_req_t      convReq,
  input  wire adc_seq_pkg::conv_rsp_t      convRsp,
  input  wire logic [adc_seq_pkg::NCMP-1:0] faultTrig
);
  import adc_seq_pkg::*;
  logic waitReg;
  // Tracks a conversion in flight; the core takes only one at a time
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      waitReg <= 1'b0;
    else if (convReq.start)
      waitReg <= 1'b1;
    else if (convRsp.done)
      waitReg <= 1'b0;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_errAccess;
    apbRsp.pslverr |-> apbReq.psel && apbReq.penable && apbRsp.prdata == '0;
  endproperty
  a_errAccess: assert property (p_errAccess)
    else $error("error response outside access or with data");
  property p_startPulse;
    convReq.start |=> !convReq.start;
  endproperty
  a_startPulse: assert property (p_startPulse)
    else $error("start longer than one cycle");
  property p_oneInFlight;
    convReq.start |-> !waitReg;
  endproperty
  a_oneInFlight: assert property (p_oneInFlight)
    else $error("start before previous conversion done");
  property p_chStable;
    $changed(convReq.ch) |-> convReq.start;
  endproperty
  a_chStable: assert property (p_chStable)
    else $error("channel changed without start");
  property p_chRange;
    convReq.start |-> convReq.ch <= CH_TEMP;
  endproperty
  a_chRange: assert property (p_chRange)
    else $error("channel out of range");
  property p_faultCause;
    faultTrig != '0 |-> $past(convRsp.done, 2) || $past(convRsp.done, 3)
      || $past(convRsp.done, 4);
  endproperty
  a_faultCause: assert property (p_faultCause)
    else $error("fault pulse without a fresh result");
  property p_faultPulse;
    faultTrig != '0 |=> faultTrig == '0;
  endproperty
  a_faultPulse: assert property (p_faultPulse)
    else $error("fault output longer than one cycle");
  property p_faultOneHot;
    $onehot0(faultTrig);
  endproperty
  a_faultOneHot: assert property (p_faultOneHot)
    else $error("several comparators fired on one result");
  c_start: cover property (convReq.start);
  c_fault: cover property (faultTrig != '0);
  c_err: cover property (apbRsp.pslverr);
endmodule : adc_sequencer_properties

// ### testbench/conv_core_model.sv
// Behavioural conversion core answering start pulses.
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire adc_seq_pkg::conv_req_t convReq,
  input  wire logic [11:0]            sampleVal,
  input  wire logic [3:0]             latency,
  output adc_seq_pkg::conv_rsp_t      convRsp
);
  import adc_seq_pkg::*;
  logic        busy;
  logic        done;
  logic [3:0]  cnt;
  logic [11:0] held;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      held <= 12'h000;
    end
    else if (convReq.start)
    begin
      busy <= 1'b1;
      cnt  <= latency;
      held <= sampleVal;
    end
    else if (busy && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else
      busy <= 1'b0;
  assign done = busy && cnt == 4'h0;
  // Inverted data outside done exposes a capture on the wrong cycle
  assign convRsp = {done, done ? held : ~held};
endmodule : conv_core_model

// ### testbench/tb_top.sv
// Self-checking bench of the converter sequencer.
`timescale 1ns/1ps
module tb_top;
  import adc_seq_pkg::*;
  localparam logic [11:0] LREF = 12'h400;
  localparam logic [11:0] HREF = 12'hC00;
  localparam logic [11:0] VALS [12] = '{12'hC01, 12'h400, 12'h400,
    12'h401, 12'hC00, 12'hC01, 12'hC01, 12'h000, 12'h400, 12'hC00,
    12'hFFF, 12'h401};
  logic            clk_sys;
  logic            arst_n;
  apb_req_t        apbReq;
  apb_rsp_t        apbRsp;
  logic [3:0]      trigIn;
  conv_req_t       convReq;
  conv_rsp_t       convRsp;
  logic [NCMP-1:0] faultTrig;
  logic [11:0]     sampleVal;
  logic [11:0]     fixVal;
  logic            fixOn;
  logic [3:0]      lat;
  int              seed = 34;
  int              num_errors = 0;
  int              comparisons = 0;
  int              doneCnt = 0;
  int              sumSamp = 0;
  logic [32:0]     expRd [$];
  logic [7:0]      expFault [$];
  logic [4:0]      expCh [$];
  logic [11:0]     sampQ [$];

  adc_sequencer i_adc_sequencer (.clk_sys(clk_sys), .arst_n(arst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .trigIn(trigIn), .convReq(convReq),
    .convRsp(convRsp), .faultTrig(faultTrig));
  conv_core_model i_conv_core_model (.clk_sys(clk_sys), .arst_n(arst_n),
    .convReq(convReq), .sampleVal(sampleVal), .latency(lat),
    .convRsp(convRsp));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    chk(expRd.size() + expFault.size() + expCh.size(), 0);
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input int a, input int d);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= w;
    apbReq.paddr <= 12'(a);
    apbReq.pwdata <= 32'(d);
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input int a, input int d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input int a, input int e, input logic er = 1'b0);
    expRd.push_back({er, 32'(e)});
    apb(1'b0, a, 0);
  endtask : rd

  task automatic waitD(input int n);
    int k = 0;
    while (doneCnt < n && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    // A stalled core counts as a mismatch rather than a silent pass
    if (doneCnt < n)
      num_errors++;
    repeat (4) @(posedge clk_sys);
  endtask : waitD

  task automatic run(input int m, input int n);
    int base;
    base = doneCnt;
    wr(OFS_PTRIG, m);
    waitD(base + n);
  endtask : run

  function automatic logic fire(input logic [3:0] m, input logic [1:0] b,
                                inout logic [1:0] p, inout logic a);
    logic [1:0] t;
    logic       hy;
    logic       f;
    t = (m < 5) ? BAND_LOW : (m < 7) ? BAND_MID : BAND_HIGH;
    hy = m == 3 || m == 4 || m == 9 || m == 10;
    f = m != 0 && m < 11 && b == t && (m[0] || p != b) && (!hy || a);
    if (hy && f)
      a = 1'b0;
    else if (hy && b == ((t == BAND_LOW) ? BAND_HIGH : BAND_LOW))
      a = 1'b1;
    p = b;
    return f;
  endfunction : fire

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Core gets fresh random latency every cycle, and fresh random data unless pinned
  always @(posedge clk_sys)
  begin
    sampleVal <= fixOn ? fixVal : 12'($random(seed));
    lat <= 4'($random(seed));
  end

  always @(posedge clk_sys)
  begin
    if (apbReq.psel && apbReq.penable && !apbReq.pwrite)
      chk({apbRsp.pslverr, apbRsp.prdata}, expRd.pop_front());
    if (faultTrig != '0)
      chk(faultTrig, expFault.size() ? expFault.pop_front() : 8'h0);
    if (convReq.start)
    begin
      chk(convReq.ch, expCh.size() ? expCh.pop_front() : 5'h1F);
      sampQ.push_back(sampleVal);
      sumSamp += sampleVal;
    end
    if (convRsp.done)
      doneCnt++;
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end

  initial
  begin : main
    int s, n, d, base;
    logic [1:0] b;
    logic [1:0] tp;
    logic [1:0] ip;
    logic ta, ia, ie;
    arst_n = 1'b0;
    apbReq = '0;
    trigIn = 4'h0;
    fixOn = 1'b0;
    fixVal = 12'h000;
    sampleVal = 12'h000;
    lat = 4'h0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a <= 'h44; a += 4)
      if (a != 4 && a != 'h18 && a != 'h2C && (a < 'h30 || a > 'h3C))
        rd(a, 0);
    rd('h04C, 0, 1'b1);
    rd('h002, 0, 1'b1);
    rd('h0C0, 0, 1'b1);
    wr(OFS_ENABLE, 'hF);
    for (int k = 0; k < 8; k++)
    begin
      s = k % 4;
      n = 1 << ((k > 6) ? 6 : k);
      d = (s == 3) ? 24 : s * 9;
      wr(OFS_STEP, (s << 20) | 'h20 | d);
      wr(OFS_OVSMP, k);
      sumSamp = 0;
      repeat (n) expCh.push_back(5'(d));
      run(1 << s, n);
      rd(OFS_RIS, 1 << s);
      wr(OFS_IMASK, 5);
      rd(OFS_MIS, (1 << s) & 5);
      wr(OFS_ICLR, 1 << s);
      rd(OFS_RIS, 0);
      rd(OFS_FCNT, 1 << (4 * s));
      rd(OFS_FIFO0 + 4 * s, sumSamp >> ((k > 6) ? 6 : k));
    end
    wr(OFS_OVSMP, 0);
    for (s = 0; s < 4; s++)
    begin
      d = (s == 0) ? 8 : (s == 3) ? 1 : 4;
      for (int i = 0; i < d; i++)
        wr(OFS_STEP, (s << 20) | (i << 16) | ((s * 5 + i * 7) % 24));
      sampQ.delete();
      repeat (2)
        for (int i = 0; i < d; i++)
          expCh.push_back(5'((s * 5 + i * 7) % 24));
      run(1 << s, d);
      run(1 << s, d);
      rd(OFS_FCNT, d << (4 * s));
      rd(OFS_OVF, 1 << s);
      wr(OFS_OVF, 1 << s);
      rd(OFS_OVF, 0);
      for (int i = 0; i < d; i++)
        rd(OFS_FIFO0 + 4 * s, sampQ[i]);
      rd(OFS_FIFO0 + 4 * s, 0);
      rd(OFS_UNF, 1 << s);
      wr(OFS_UNF, 1 << s);
      wr(OFS_ICLR, 'hF);
    end
    wr(OFS_STEP, 'h23);
    wr(OFS_STEP, (1 << 20) | 'h2B);
    wr(OFS_PRIO, 'h3);
    sampQ.delete();
    expCh.push_back(5'd11);
    expCh.push_back(5'd3);
    run(3, 2);
    rd(OFS_FIFO0 + 4, sampQ[0]);
    rd(OFS_FIFO0, sampQ[1]);
    wr(OFS_STEP, (2 << 20) | 'h31);
    wr(OFS_TSEL, 'h400);
    wr(OFS_ENABLE, 'hB);
    for (int e = 0; e < 2; e++)
    begin
      base = doneCnt;
      trigIn <= 4'h8;
      repeat (3) @(posedge clk_sys);
      trigIn <= 4'h0;
      if (e == 0)
      begin
        repeat (12) @(posedge clk_sys);
        chk(doneCnt, base);
        wr(OFS_ENABLE, 'hF);
        expCh.push_back(5'd17);
      end
    end
    waitD(base + 1);
    rd(OFS_FIFO0 + 8, sampQ[2]);
    wr(OFS_TSEL, 0);
    fixOn <= 1'b1;
    for (int m = 0; m < 16; m++)
    begin
      s = m % 8;
      wr(OFS_CMP + 8 * s, (((m + 5) % 16) << 4) | m);
      wr(OFS_CMP + 8 * s + 4, {4'h0, HREF, 4'h0, LREF});
      wr(OFS_STEP, (3 << 20) | (s << 7) | 'h61);
      wr(OFS_CRST, 'h101 << s);
      tp = BAND_NONE;
      ip = BAND_NONE;
      ta = 1'b0;
      ia = 1'b0;
      for (int j = 0; j < 12; j++)
      begin
        fixVal <= VALS[j];
        b = (VALS[j] <= LREF) ? BAND_LOW
          : (VALS[j] <= HREF) ? BAND_MID : BAND_HIGH;
        if (fire(4'(m), b, tp, ta))
          expFault.push_back(8'h1 << s);
        ie = fire(4'((m + 5) % 16), b, ip, ia);
        expCh.push_back(5'd1);
        run(8, 1);
        rd(OFS_CRIS, int'(ie) << s);
        wr(OFS_CRIS, 'hFF);
        rd(OFS_FIFO3, VALS[j]);
        chk(expFault.size(), 0);
      end
    end
    end_sim();
  end
endmodule : tb_top

bind adc_sequencer adc_sequencer_properties i_adc_sequencer_properties (
  .clk_sys(clk_sys), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .trigIn(trigIn), .convReq(convReq), .convRsp(convRsp),
  .faultTrig(faultTrig));
